/* verilog/hbsir_defs.vh */
`ifndef HBSIR_DEFS_VH
`define HBSIR_DEFS_VH
// ----------------------------------------
// Field positions
// ----------------------------------------
`define HBSIR_ADDR_W 15
`define HBSIR_DEC_LSB 4
`define HBSIR_DEC_MSB 15
`define HBSIR_BASE_HI_W 8
`define HBSIR_IRQ_SEL_W 2
`define HBSIR_IRQ_PINS 4
`define HBSIR_DATA_W 32
`define HBSIR_BE_W 4
// ----------------------------------------
// Reset values and the all-lanes constant
// ----------------------------------------
`define HBSIR_BASE_HI_RST 8'h30
`define HBSIR_IRQ_SEL_RST 2'h0
`define HBSIR_IRQ_OE_RST 4'h1
`define HBSIR_LANES_RST 4'h0
`define HBSIR_LANES_ALL 4'hf
`endif

/* verilog/hbsir_sync2.v */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Two-flop synchroniser for pin inputs
// ----------------------------------------
module hbsir_sync2 #(
  parameter RST_VAL = 1'b0
) (
  input wire clk_i,
  input wire resetn_i,
  input wire ce_i,
  input wire d_i,
  output wire q_o
);
  reg meta;
  reg sync;
  // First stage feeds only the second
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta <= RST_VAL;
      sync <= RST_VAL;
    end else if (ce_i) begin
      meta <= d_i;
      sync <= meta;
    end
  end
  assign q_o = sync;
endmodule // hbsir_sync2
`default_nettype wire

/* verilog/hbsir_top.v */
// What this block does
// R1: Burst mode: sample ready-return on falling clock
// R2: Host drives ready-return low to complete reads; burst cycles here complete on ready-return high instead
// R3: One interrupt pin driven, others floated
// R4: Interrupt pin chosen by two-bit select field
// R5: Decode output needs address enable low, match
// R6: Decode output purely combinational, unlatched address
// R7: Chip select grants datapath, ignores address
// R8: Datapath bursts move full 32-bit words
// R9: Byte enables ignored during datapath access
// R10: Style input picks VL or burst cycles
// R11: Address decode only while address enable low
// R12: Select values 0..3 map to pins 0..3
`timescale 1ns/100ps
`default_nettype none
`include "hbsir_defs.vh"
module hbsir_top (
  input wire clk_i,
  input wire resetn_i,
  input wire ce_i,
  // Host address side
  input wire [`HBSIR_ADDR_W:1] addr_i,
  input wire addr_enable_n_i,
  input wire [`HBSIR_BE_W-1:0] byte_lane_enable_n_i,
  input wire datapath_chip_select_n_i,
  input wire sync_bus_style_n_i,
  input wire local_bus_clock_i,
  input wire ready_return_n_i,
  // Configuration
  input wire [`HBSIR_BASE_HI_W-1:0] io_base_high_i,
  input wire [`HBSIR_IRQ_SEL_W-1:0] irq_line_select_i,
  input wire irq_i,
  // Synchronous cycle from the core
  input wire sync_req_i,
  output wire sync_done_o,
  output wire sync_pending_o,
  output wire burst_mode_o,
  // Datapath access
  output wire datapath_access_o,
  output wire [`HBSIR_BE_W-1:0] eff_byte_enable_o,
  output wire register_access_o,
  // Pins
  output wire local_device_decode_n_o,
  output wire [`HBSIR_IRQ_PINS-1:0] irq_out_pins_o,
  output wire [`HBSIR_IRQ_PINS-1:0] irq_out_pins_oe_o
);
  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // No register in path: host sees decode within its own address phase
  // Only A15..A8 carry the base; A7..A4 must be zero, so the window
  // spans the sixteen bytes that A3..A1 select
  wire dec_match;
  assign dec_match = (addr_i[`HBSIR_DEC_MSB:`HBSIR_DEC_LSB] == {io_base_high_i, 4'h0}); // [R5]
  assign local_device_decode_n_o = ~(~addr_enable_n_i & dec_match); // [R6] [R11]
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Every sampled pin level crosses into clk_i through two flops first
  wire local_bus_clock_s;
  wire rdy_n_s;
  wire dcs_n_s;
  wire style_n_s;
  wire [`HBSIR_BE_W-1:0] be_n_s;
  wire dec_n_s;
  hbsir_sync2 #(.RST_VAL(1'b0)) u_sync_local_bus_clock (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .d_i(local_bus_clock_i), .q_o(local_bus_clock_s));
  hbsir_sync2 #(.RST_VAL(1'b1)) u_sync_rdy (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .d_i(ready_return_n_i), .q_o(rdy_n_s));
  hbsir_sync2 #(.RST_VAL(1'b1)) u_sync_dcs (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .d_i(datapath_chip_select_n_i), .q_o(dcs_n_s));
  hbsir_sync2 #(.RST_VAL(1'b1)) u_sync_style (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .d_i(sync_bus_style_n_i), .q_o(style_n_s));
  // Lanes and the decode hit are pin levels too, so they get the same
  // two stages; the decode pin itself stays unregistered
  hbsir_sync2 #(.RST_VAL(1'b1)) u_sync_be0 (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .d_i(byte_lane_enable_n_i[0]), .q_o(be_n_s[0]));
  hbsir_sync2 #(.RST_VAL(1'b1)) u_sync_be1 (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .d_i(byte_lane_enable_n_i[1]), .q_o(be_n_s[1]));
  hbsir_sync2 #(.RST_VAL(1'b1)) u_sync_be2 (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .d_i(byte_lane_enable_n_i[2]), .q_o(be_n_s[2]));
  hbsir_sync2 #(.RST_VAL(1'b1)) u_sync_be3 (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .d_i(byte_lane_enable_n_i[3]), .q_o(be_n_s[3]));
  hbsir_sync2 #(.RST_VAL(1'b1)) u_sync_dec (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .d_i(local_device_decode_n_o), .q_o(dec_n_s));
  // ----------------------------------------
  // Local clock edge detect
  // ----------------------------------------
  // Resets low like the idle link clock, so no false rise follows reset
  // Limitation: link clock must stay below a quarter of clk_i
  reg local_bus_clock_d;
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      local_bus_clock_d <= 1'b0;
    end else if (ce_i) begin
      local_bus_clock_d <= local_bus_clock_s;
    end
  end
  wire local_bus_clock_fall;
  wire local_bus_clock_rise;
  assign local_bus_clock_fall = local_bus_clock_d & ~local_bus_clock_s;
  assign local_bus_clock_rise = ~local_bus_clock_d & local_bus_clock_s;
  // ----------------------------------------
  // Completion qualifiers
  // ----------------------------------------
  // Ready and the link clock share sync depth, so both are seen together
  // Burst ends on a fall with ready high, VL on a rise with ready low
  wire burst_ready_seen;
  wire vl_ready_seen;
  assign burst_ready_seen = local_bus_clock_fall & rdy_n_s; // [R1]
  assign vl_ready_seen = local_bus_clock_rise & ~rdy_n_s; // [R10]
  // ----------------------------------------
  // Synchronous cycle control
  // ----------------------------------------
  localparam ST_IDLE = 3'h1;
  localparam ST_WAIT = 3'h2;
  localparam ST_DONE = 3'h4;
  reg [2:0] state;
  reg [2:0] next_state;
  reg burst_mode;
  // Style latched per cycle so a mid-cycle pin change cannot split a cycle
  // A style change while a cycle is pending takes effect on the next
  // request only
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (sync_req_i) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Burst: held until ready-return seen high at a falling edge
        if (burst_mode) begin
          if (burst_ready_seen) begin // [R1]
            next_state = ST_DONE;
          end
        end else if (vl_ready_seen) begin // [R2] [R10]
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end
  // State register and the style latched at each request
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= ST_IDLE;
      burst_mode <= 1'b0;
    end else if (ce_i) begin
      state <= next_state;
      if (state == ST_IDLE) begin
        burst_mode <= style_n_s; // [R10]
      end
    end
  end
  // Status straight from the state register
  assign sync_done_o = (state == ST_DONE);
  assign sync_pending_o = (state == ST_WAIT);
  assign burst_mode_o = burst_mode;
  // ----------------------------------------
  // Datapath select and byte lanes
  // ----------------------------------------
  reg dp_access;
  reg [`HBSIR_BE_W-1:0] eff_be;
  reg reg_access;
  // Chip select overrides address, enable and byte lanes; forces full words
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dp_access <= 1'b0;
      eff_be <= `HBSIR_LANES_RST;
      reg_access <= 1'b0;
    end else if (ce_i) begin
      dp_access <= ~dcs_n_s; // [R7] [R8]
      if (!dcs_n_s) begin
        eff_be <= `HBSIR_LANES_ALL; // [R9]
        reg_access <= 1'b0; // [R7]
      end else begin
        // Register hit lags the decode pin by the two sync stages and this register
        eff_be <= ~be_n_s; // [R9]
        reg_access <= ~dec_n_s; // [R5] [R11]
      end
    end
  end
  assign datapath_access_o = dp_access;
  assign eff_byte_enable_o = eff_be;
  assign register_access_o = reg_access;
  // ----------------------------------------
  // Interrupt pin steering
  // ----------------------------------------
  reg [`HBSIR_IRQ_PINS-1:0] irq_oe;
  reg irq_lvl;
  // Enables follow the select one cycle later; unselected pins float so
  // they never fight another card on a shared line
  // Level delayed with them so pin and enable change together
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_oe <= `HBSIR_IRQ_OE_RST;
      irq_lvl <= 1'b0;
    end else if (ce_i) begin
      irq_oe <= 4'h1 << irq_line_select_i; // [R3] [R4] [R12]
      irq_lvl <= irq_i;
    end
  end
  // Data masked by its enable, so a floated pin reads low here
  assign irq_out_pins_o = {`HBSIR_IRQ_PINS{irq_lvl}} & irq_oe;
  assign irq_out_pins_oe_o = irq_oe; // [R3]
endmodule // hbsir_top
`default_nettype wire

/* testbench/hbsir_top_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module hbsir_top_asserts (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [15:1] addr_i,
  input wire logic addr_enable_n_i,
  input wire logic [7:0] io_base_high_i,
  input wire logic [1:0] irq_line_select_i,
  input wire logic irq_i,
  input wire logic datapath_chip_select_n_i,
  input wire logic sync_done_o,
  input wire logic sync_pending_o,
  input wire logic datapath_access_o,
  input wire logic [3:0] eff_byte_enable_o,
  input wire logic local_device_decode_n_o,
  input wire logic [3:0] irq_out_pins_o,
  input wire logic [3:0] irq_out_pins_oe_o
);
  // One domain, so clock and reset are given once
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  a_decode_exact: assert property (local_device_decode_n_o ==
    !(!addr_enable_n_i && addr_i[15:4] == {io_base_high_i, 4'h0})) else $error("bad decode");
  a_irq_onehot: assert property ($onehot(irq_out_pins_oe_o)) else $error("bad oe");
  a_irq_select: assert property ($past(resetn_i) |->
    irq_out_pins_oe_o == 4'h1 << $past(irq_line_select_i)) else $error("bad pin choice");
  a_irq_level: assert property ($past(resetn_i) |->
    |(irq_out_pins_o & irq_out_pins_oe_o) == $past(irq_i)) else $error("bad irq level");
  // Sync stages plus output reg need three edges, five gives margin
  a_dp_grant: assert property (!datapath_chip_select_n_i [*5] |->
    datapath_access_o && eff_byte_enable_o == 4'hf) else $error("no grant");
  a_dp_release: assert property (datapath_chip_select_n_i [*5] |->
    !datapath_access_o) else $error("stuck grant");
  a_done_pulse: assert property (sync_done_o |->
    !sync_pending_o ##1 !sync_done_o) else $error("bad done");
  a_pend_bound: assert property ($rose(sync_pending_o) |->
    ##[1:400] sync_done_o) else $error("hung cycle");
endmodule // hbsir_top_asserts
bind hbsir_top hbsir_top_asserts chk (.clk_i, .resetn_i, .addr_i, .addr_enable_n_i,
  .io_base_high_i, .irq_line_select_i, .irq_i, .datapath_chip_select_n_i, .sync_done_o,
  .sync_pending_o, .datapath_access_o, .eff_byte_enable_o, .local_device_decode_n_o,
  .irq_out_pins_o, .irq_out_pins_oe_o);
`default_nettype wire

/* testbench/hbsir_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module hbsir_host_model (
  input wire logic run_i,
  input wire logic burst_i,
  input wire logic [3:0] wait_i,
  output logic local_bus_clock_o,
  output logic ready_return_n_o
);
  int n;
  // Link clock still outside frames; ready held back wait_i periods
  initial begin
    local_bus_clock_o = 1'b0;
    ready_return_n_o = 1'b1;
    forever begin
      wait (run_i);
      // Off the bench clock edges, so no sample races a change
      #2;
      for (n = 0; run_i; n++) begin
        // Ready settles mid-phase, well before the edge that samples it
        #40 ready_return_n_o = (n < wait_i) ^ burst_i;
        #40 local_bus_clock_o = 1'b1;
        #80 local_bus_clock_o = 1'b0;
      end
      ready_return_n_o = 1'b1;
    end
  end
endmodule // hbsir_host_model
`default_nettype wire

/* testbench/hbsir_top_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module hbsir_top_bench;
  logic clk_i = 1'b0, resetn_i = 1'b0, ce_i = 1'b1, addr_enable_n_i = 1'b1, run = 1'b0;
  logic datapath_chip_select_n_i = 1'b1, sync_bus_style_n_i = 1'b0, irq_i = 1'b0;
  logic sync_req_i = 1'b0, local_bus_clock_i, ready_return_n_i, sync_done_o, sync_pending_o;
  logic burst_mode_o, datapath_access_o, register_access_o, local_device_decode_n_o;
  logic [15:1] addr_i = 15'h0000;
  logic [3:0] byte_lane_enable_n_i = 4'h0, wt = 4'h0, eff_byte_enable_o;
  logic [3:0] irq_out_pins_o, irq_out_pins_oe_o;
  logic [7:0] io_base_high_i = 8'h30;
  logic [1:0] irq_line_select_i = 2'h0;
  int n_fail = 0, samples_checked = 0, cyc = 0, k;
  always #4 clk_i = ~clk_i;
  hbsir_host_model host (.run_i(run), .burst_i(sync_bus_style_n_i), .wait_i(wt),
    .local_bus_clock_o(local_bus_clock_i), .ready_return_n_o(ready_return_n_i));
  hbsir_top DUT (.clk_i, .resetn_i, .ce_i, .addr_i, .addr_enable_n_i, .byte_lane_enable_n_i,
    .datapath_chip_select_n_i, .sync_bus_style_n_i, .local_bus_clock_i, .ready_return_n_i,
    .io_base_high_i, .irq_line_select_i, .irq_i, .sync_req_i, .sync_done_o, .sync_pending_o,
    .burst_mode_o, .datapath_access_o, .eff_byte_enable_o, .register_access_o,
    .local_device_decode_n_o, .irq_out_pins_o, .irq_out_pins_oe_o);
  function automatic logic exp_dec(logic [15:1] a, logic e, logic [7:0] b);
    return !(!e && a[15:4] == {b, 4'h0});
  endfunction
  task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    k = $urandom(32'h474d);
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    // Random decode, half of them forced onto the base
    repeat (60) begin
      @(posedge clk_i);
      k = $urandom;
      io_base_high_i <= k[7:0];
      addr_enable_n_i <= k[8];
      byte_lane_enable_n_i <= k[31:28];
      addr_i <= k[9] ? {k[7:0], 4'h0, k[12:10]} : k[24:10];
      @(negedge clk_i);
      chk("decode", exp_dec(addr_i, addr_enable_n_i, io_base_high_i),
        local_device_decode_n_o);
    end
    $display("test decode done");
    for (int s = 0; s < 4; s++) begin
      @(posedge clk_i);
      irq_line_select_i <= s[1:0];
      irq_i <= s[0];
      repeat (2) @(posedge clk_i);
      #1;
      chk("irq_oe", 8'h01 << s, irq_out_pins_oe_o);
      chk("irq_pin", s[0], irq_out_pins_o[s]);
    end
    $display("test irq done");
    // Chip select with a decode hit: datapath wins
    @(posedge clk_i);
    datapath_chip_select_n_i <= 1'b0;
    addr_enable_n_i <= 1'b0;
    addr_i <= {io_base_high_i, 4'h0, 3'h1};
    repeat (5) @(posedge clk_i);
    #1;
    chk("dp_access", 1, datapath_access_o);
    chk("dp_lanes", 8'h0f, eff_byte_enable_o);
    chk("reg_access", 0, register_access_o);
    @(posedge clk_i);
    datapath_chip_select_n_i <= 1'b1;
    byte_lane_enable_n_i <= 4'h9;
    // Select released with the decode still hitting: register path again
    repeat (5) @(posedge clk_i);
    #1;
    chk("reg_access_hit", 1, register_access_o);
    chk("reg_lanes", 8'h06, eff_byte_enable_o);
    $display("test datapath done");
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_i);
      sync_bus_style_n_i <= m[0];
      wt <= m[1] ? 4'h3 : 4'h0;
      repeat (4) @(posedge clk_i);
      run <= 1'b1;
      sync_req_i <= 1'b1;
      @(posedge clk_i);
      sync_req_i <= 1'b0;
      k = 0;
      do begin
        @(posedge clk_i);
        #1;
        k++;
      end while (sync_done_o !== 1'b1 && k < 400);
      chk("sync_done", 1, sync_done_o);
      chk("burst_mode", m[0], burst_mode_o);
      chk("ready_level", m[0], ready_return_n_i);
      @(posedge clk_i);
      run <= 1'b0;
      // Let the host end its period and park the link clock
      repeat (25) @(posedge clk_i);
    end
    $display("test sync done");
    // Reset in mid-run: outputs fall back to their idle values
    @(posedge clk_i);
    resetn_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk("rst_oe", 8'h01, irq_out_pins_oe_o);
    chk("rst_pins", 8'h00, irq_out_pins_o);
    chk("rst_lanes", 8'h00, eff_byte_enable_o);
    chk("rst_dp", 0, datapath_access_o);
    @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    chk("post_rst_oe", 8'h01 << irq_line_select_i, irq_out_pins_oe_o);
    $display("test reset done");
    report_and_stop();
  end
endmodule // hbsir_top_bench
`default_nettype wire
